// ===== bench/tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------
// bus tasks, step bursts and queued expectations
// ------------------------------------------------
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, lfsr = 32'hD04D;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tick_prio;
  logic        clk_256hz, slow_osc_clk, fast_osc_clk, freq_out_pin, level_one_request, irq;
  logic [15:0] target = '0, step_cnt;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          err_total = 0, check_count = 0, cyc = 0, edges = 0, k;
  clock_timer_with_freq_out dut (.*);
  tick_partner src (.aclk, .target, .clk_256hz, .slow_osc_clk, .fast_osc_clk, .step_cnt);
  initial forever #25 aclk = ~aclk;
  always @(freq_out_pin) edges++;
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // response ready rises in the cycle the write answer appears, so the slave never has to hold it
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [17:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic steps(input logic [15:0] n);
    logic [15:0] t;
    t = target + n;
    target <= t;
    while (step_cnt != t) @(posedge aclk);
    repeat (12) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(tick_pkg::PRIO_ADDR, 34'h0);
    rd(tick_pkg::ENABLE_ADDR, 34'h0);
    rd(tick_pkg::FLAG_ADDR, 34'h0);
    rd(tick_pkg::CTRL_ADDR, 34'h0);
    rd(tick_pkg::VALUE_ADDR, 34'h0);
    rd(18'h00010, 34'h200000000);
    wr(18'h00010, 32'h1, tick_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      wr(tick_pkg::PRIO_ADDR, lfsr);
      rd(tick_pkg::PRIO_ADDR, {32'h0, lfsr[1:0]});
      check({32'h0, tick_prio}, {32'h0, lfsr[1:0]});
      wr(tick_pkg::ENABLE_ADDR, {24'h0, lfsr[15:8]});
      rd(tick_pkg::ENABLE_ADDR, {30'h0, lfsr[11:8]});
    end
    wr(tick_pkg::CTRL_ADDR, 32'hFFFFFFFF);
    rd(tick_pkg::CTRL_ADDR, 34'h79);
    wr(tick_pkg::VALUE_ADDR, 32'hFF);
    rd(tick_pkg::VALUE_ADDR, 34'h0);
    $display("test registers done");
    for (int s = 0; s < 8; s++) begin
      wr(tick_pkg::CTRL_ADDR, 32'h08 | (s << 4));
      edges = 0;
      repeat (200) @(posedge aclk);
      // half period of the chosen tap: partner toggles slow every 5 cycles, fast every cycle
      k = (s[2] ? 1 : 5) << s[1:0];
      check({33'h0, edges >= 200 / k - 1 && edges <= 200 / k + 1}, 34'h1);
      wr(tick_pkg::CTRL_ADDR, s << 4);
      repeat (4) @(posedge aclk);
      edges = 0;
      repeat (100) @(posedge aclk);
      check({33'h0, edges > 0}, 34'h0);
    end
    $display("test frequency output done");
    wr(tick_pkg::ENABLE_ADDR, 32'h0);
    wr(tick_pkg::CTRL_ADDR, 32'h03);
    steps(5);
    rd(tick_pkg::VALUE_ADDR, 34'h5);
    steps(250);
    rd(tick_pkg::VALUE_ADDR, 34'hFF);
    rd(tick_pkg::FLAG_ADDR, 34'hE);
    wr(tick_pkg::CTRL_ADDR, 32'h00);
    steps(3);
    rd(tick_pkg::VALUE_ADDR, 34'h0);
    rd(tick_pkg::FLAG_ADDR, 34'hF);
    check({33'h0, level_one_request}, 34'h0);
    wr(tick_pkg::ENABLE_ADDR, 32'h1);
    check({33'h0, level_one_request}, 34'h1);
    wr(tick_pkg::FLAG_ADDR, 32'h0);
    rd(tick_pkg::FLAG_ADDR, 34'hF);
    wr(tick_pkg::FLAG_ADDR, 32'h6);
    rd(tick_pkg::FLAG_ADDR, 34'h9);
    wr(tick_pkg::FLAG_ADDR, 32'hF);
    check({33'h0, level_one_request}, 34'h0);
    wr(tick_pkg::CTRL_ADDR, 32'h01);
    steps(4);
    rd(tick_pkg::VALUE_ADDR, 34'h4);
    wr(tick_pkg::CTRL_ADDR, 32'h02);
    rd(tick_pkg::VALUE_ADDR, 34'h0);
    $display("test counting done");
    check({33'h0, irq}, 34'h0);
    wr(tick_pkg::MASK_ADDR, 32'h1);
    check({33'h0, irq}, 34'h1);
    wr(tick_pkg::MASK_ADDR, 32'h0);
    check({33'h0, irq}, 34'h0);
    rd(tick_pkg::STAT_ADDR, 34'hF);
    wr(tick_pkg::STAT_ADDR, 32'hF);
    rd(tick_pkg::STAT_ADDR, 34'h0);
    wr(tick_pkg::MASK_ADDR, 32'hF);
    check({33'h0, irq}, 34'h0);
    $display("test interrupt done");
    close_out();
  end
endmodule // tb_top

// ===== bench/tick_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------
// pin relations of the timer block
// ------------------------------------------------
module tick_checker (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, low
  input wire logic [17:0] s_axi_awaddr,  // aw addr
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata,   // w data
  input wire logic [3:0]  s_axi_wstrb,   // w strobes
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // r data
  input wire logic [1:0]  s_axi_rresp,   // r resp
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        freq_out_pin,  // freq pin
  input wire logic [1:0]  tick_prio      // priority
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       wr_go;
  logic [1:0] prio_w_reg;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  // held until the next priority write, which cannot land inside the check window
  always_ff @(posedge aclk) begin
    if (wr_go && s_axi_awaddr == tick_pkg::PRIO_ADDR) prio_w_reg <= s_axi_wdata[1:0];
  end
  a_prio_write: assert property (wr_go && s_axi_awaddr == tick_pkg::PRIO_ADDR
    |-> ##[1:3] tick_prio == prio_w_reg) else $error("priority write not seen");
  a_prio_reset: assert property ($rose(aresetn) |-> tick_prio == 2'b00)
    else $error("priority not zero after reset");
  a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  // both halves are parked for a cycle before the response register is loaded
  a_write_turn: assert property (wr_go |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == tick_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h00000000) else $error("error read not zero");
  a_freq_off: assert property (wr_go && s_axi_awaddr == tick_pkg::CTRL_ADDR
    && !s_axi_wdata[3] |-> ##3 !freq_out_pin) else $error("pin not gated off");
endmodule // tick_checker

bind clock_timer_with_freq_out tick_checker chk (.*);

// ===== bench/tick_partner.sv
`timescale 1ns/1ps
// ------------------------------------------------
// far side: 256 Hz step source and both oscillators
// ------------------------------------------------
module tick_partner #(
  parameter int HALF = 6            // aclk cycles per half step period
) (
  input  wire logic [15:0] target,   // total steps wanted so far
  input  wire logic        aclk,     // system clock
  output logic             clk_256hz,    // step clock, low between bursts
  output logic             slow_osc_clk, // slow oscillator
  output logic             fast_osc_clk, // fast oscillator
  output logic [15:0]      step_cnt  // rising edges given
);
  int ph = 0;
  initial begin
    {clk_256hz, slow_osc_clk, fast_osc_clk} = 3'b000;
    step_cnt = '0;
  end
  always @(posedge aclk) begin
    ph <= ph + 1;
    fast_osc_clk <= ~fast_osc_clk;
    if (ph % 5 == 0) slow_osc_clk <= ~slow_osc_clk;
    // a burst always ends low, so the timer never sees a half step
    if (ph % HALF == 0) begin
      if (clk_256hz) clk_256hz <= 1'b0;
      else if (step_cnt < target) begin
        clk_256hz <= 1'b1;
        step_cnt <= step_cnt + 16'h0001;
      end
    end
  end
endmodule // tick_partner

// ===== src/clock_timer_with_freq_out.sv
`timescale 1ns/1ps
// Contract
// - a three-bit code picks slow oscillator /1,/2,/4,/8 or fast /1,/2,/4,/8, and an on bit gates the pin.
// - the timer advances while the run bit (control bit 0) is one and for one step after it clears; it resets to stopped.
// - the read-only value byte shows the 128 Hz tap at bit 0 down to 1 Hz at bit 7, reset zero.
// - a two-bit priority field in bits 1:0 selects level 0 to 3 and resets to zero.
// - four read/write enables for 32, 8, 2 and 1 Hz events sit at bits 3 down to 0, reset zero.
// - each 32, 8, 2 or 1 Hz event sets its factor flag at bits 3 down to 0.
// - writing one to a factor flag clears it, writing zero leaves it.
// - after run is cleared the count advances one more 256 Hz step before it stops.
// - flags are set on every event, the stopping step included; a request needs the enable.
module clock_timer_with_freq_out (
  input  wire logic        aclk,          // system clock, 20 MHz
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic [17:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [17:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        clk_256hz,     // 256 Hz timer input, async
  input  wire logic        slow_osc_clk,  // slow oscillator, async
  input  wire logic        fast_osc_clk,  // fast oscillator, async
  output logic             freq_out_pin,  // frequency output
  output logic             level_one_request, // timer request toward cpu
  output logic [1:0]       tick_prio,     // timer priority level
  output logic             irq            // status/mask interrupt
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sync_256;
    logic [1:0] sync_slow;
    logic [1:0] sync_fast;
    logic       aw_held;
    logic [17:0] aw_addr;
    logic       w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic       run;
    logic       stop_pending;
    logic [2:0] sel;
    logic       on;
    logic [7:0] value;
    logic [1:0] prio;
    logic [3:0] enable;
    logic [3:0] flag;
    logic [3:0] mask;
    logic [3:0] stat;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic       tick;
  logic       active;
  logic [7:0] value_inc;
  logic [3:0] events;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wbyte;
  logic       wlane;
  logic [31:0] rd_word;
  logic       rd_ok;

  // ---------------------------------------------------------------
  // frequency output
  // ---------------------------------------------------------------
  osc_divider u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .slow_osc (st_reg.sync_slow[1]),
    .fast_osc (st_reg.sync_fast[1]),
    .sel      (st_reg.sel),
    .on       (st_reg.on),
    .freq_out (freq_out_pin)
  );

  always_comb begin
    st_next = st_reg;
    // two-stage synchronisers; stage 2 of 256 Hz also feeds an edge register
    st_next.sync_256  = {st_reg.sync_256[1], st_reg.sync_256[0], clk_256hz};
    st_next.sync_slow = {st_reg.sync_slow[0], slow_osc_clk};
    st_next.sync_fast = {st_reg.sync_fast[0], fast_osc_clk};
    tick = st_reg.sync_256[1] & ~st_reg.sync_256[2];

    // ---------------------------------------------------------------
    // timer chain
    // ---------------------------------------------------------------
    // stop is deferred so that the step in flight still completes
    active    = st_reg.run | st_reg.stop_pending;
    value_inc = st_reg.value + 8'h01;
    events    = 4'h0;
    if (tick && active) begin
      st_next.value = value_inc;
      st_next.stop_pending = 1'b0;
      // an event is the falling edge of its tap
      events = {st_reg.value[tick_pkg::TAP_32] & ~value_inc[tick_pkg::TAP_32],
                st_reg.value[tick_pkg::TAP_8]  & ~value_inc[tick_pkg::TAP_8],
                st_reg.value[tick_pkg::TAP_2]  & ~value_inc[tick_pkg::TAP_2],
                st_reg.value[tick_pkg::TAP_1]  & ~value_inc[tick_pkg::TAP_1]};
    end

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    wbyte = st_reg.w_data[7:0];
    wlane = st_reg.w_strb[0];
    if (wr_go) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = tick_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        tick_pkg::CTRL_ADDR: begin
          if (wlane) begin
            if (st_reg.run && !wbyte[tick_pkg::CTRL_RUN_BIT]) begin
              st_next.stop_pending = 1'b1;
            end
            st_next.run = wbyte[tick_pkg::CTRL_RUN_BIT];
            st_next.on  = wbyte[tick_pkg::CTRL_ON_BIT];
            st_next.sel = wbyte[tick_pkg::CTRL_SEL_LSB +: 3];
            if (wbyte[tick_pkg::CTRL_CLEAR_BIT]) begin
              st_next.value = tick_pkg::ZERO_BYTE;
              events = 4'h0;
            end
          end
        end
        tick_pkg::PRIO_ADDR: if (wlane) st_next.prio = wbyte[1:0];
        tick_pkg::ENABLE_ADDR: if (wlane) st_next.enable = wbyte[3:0];
        tick_pkg::FLAG_ADDR: if (wlane) st_next.flag = st_reg.flag & ~wbyte[3:0];
        tick_pkg::MASK_ADDR: if (wlane) st_next.mask = wbyte[3:0];
        tick_pkg::STAT_ADDR: if (wlane) st_next.stat = st_reg.stat & ~wbyte[3:0];
        tick_pkg::VALUE_ADDR: st_next.bresp = tick_pkg::RESP_OKAY;
        default: st_next.bresp = tick_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // set wins over a clear in the same cycle
    st_next.flag = st_next.flag | events;
    st_next.stat = st_next.stat | events;

    rd_go = s_axi_arvalid && !st_reg.rvalid;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      tick_pkg::CTRL_ADDR: rd_word = {24'h000000, 1'b0, st_reg.sel, st_reg.on, 2'b00,
                                      st_reg.run};
      tick_pkg::VALUE_ADDR: rd_word = {24'h000000, st_reg.value};
      tick_pkg::PRIO_ADDR: rd_word = {30'h00000000, st_reg.prio};
      tick_pkg::ENABLE_ADDR: rd_word = {28'h0000000, st_reg.enable};
      tick_pkg::FLAG_ADDR: rd_word = {28'h0000000, st_reg.flag};
      tick_pkg::MASK_ADDR: rd_word = {28'h0000000, st_reg.mask};
      tick_pkg::STAT_ADDR: rd_word = {28'h0000000, st_reg.stat};
      default: begin
        rd_word = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word;
      st_next.rresp  = rd_ok ? tick_pkg::RESP_OKAY : tick_pkg::RESP_SLVERR;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready  = !st_reg.w_held;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign level_one_request = |(st_reg.flag & st_reg.enable);
  assign tick_prio     = st_reg.prio;
  assign irq           = |(st_reg.stat & st_reg.mask);
endmodule // clock_timer_with_freq_out

// ===== src/osc_divider.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// selectable oscillator divider for the frequency output pin
// ---------------------------------------------------------------
module osc_divider (
  input  wire logic       aclk,       // system clock
  input  wire logic       aresetn,    // sync reset, active low
  input  wire logic       slow_osc,   // synchronised slow oscillator level
  input  wire logic       fast_osc,   // synchronised fast oscillator level
  input  wire logic [2:0] sel,        // source and divide code
  input  wire logic       on,         // output gate
  output logic            freq_out    // divided output, registered
);
  typedef struct packed {
    logic       slow_d;
    logic       fast_d;
    logic [2:0] slow_cnt;
    logic [2:0] fast_cnt;
    logic       out;
  } div_s;

  div_s st_reg;
  div_s st_next;
  logic [3:0] slow_taps;
  logic [3:0] fast_taps;

  always_comb begin
    st_next = st_reg;
    st_next.slow_d = slow_osc;
    st_next.fast_d = fast_osc;
    // ripple count on falling input edges: bit n toggles at osc / 2^(n+1)
    if (st_reg.slow_d && !slow_osc) begin
      st_next.slow_cnt = st_reg.slow_cnt + 3'h1;
    end
    if (st_reg.fast_d && !fast_osc) begin
      st_next.fast_cnt = st_reg.fast_cnt + 3'h1;
    end
    slow_taps = {st_reg.slow_cnt, slow_osc};
    fast_taps = {st_reg.fast_cnt, fast_osc};
    st_next.out = on & (sel[2] ? fast_taps[sel[1:0]] : slow_taps[sel[1:0]]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign freq_out = st_reg.out;
endmodule // osc_divider

// ===== src/tick_pkg.sv
package tick_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] PRIO_OFS   = 16'hFF20;
  localparam logic [15:0] ENABLE_OFS = 16'hFF22;
  localparam logic [15:0] FLAG_OFS   = 16'hFF24;
  localparam logic [15:0] CTRL_OFS   = 16'hFF40;
  localparam logic [15:0] VALUE_OFS  = 16'hFF41;
  // the printed offsets are not all multiples of four: byte address is 4 * index
  localparam logic [17:0] PRIO_ADDR   = {PRIO_OFS, 2'b00};
  localparam logic [17:0] ENABLE_ADDR = {ENABLE_OFS, 2'b00};
  localparam logic [17:0] FLAG_ADDR   = {FLAG_OFS, 2'b00};
  localparam logic [17:0] CTRL_ADDR   = {CTRL_OFS, 2'b00};
  localparam logic [17:0] VALUE_ADDR  = {VALUE_OFS, 2'b00};
  localparam logic [17:0] MASK_ADDR   = 18'h3FD50;
  localparam logic [17:0] STAT_ADDR   = 18'h3FD54;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_ON_BIT    = 3;
  localparam int CTRL_SEL_LSB   = 4;
  localparam logic [7:0] CTRL_RW_MASK = 8'h79;
  localparam logic [7:0] PRIO_MASK    = 8'h03;
  localparam logic [7:0] NIB_MASK     = 8'h0F;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // tap index of each event in the 8-bit value: 32, 8, 2, 1 Hz
  localparam int TAP_32 = 2;
  localparam int TAP_8  = 4;
  localparam int TAP_2  = 6;
  localparam int TAP_1  = 7;
endpackage
